// >>> verilog/cts_timer_set.sv
`timescale 1ns/1ps
`include "cts_map.svh"
module cts_timer_set
  import cts_pkg::*;
#(
  parameter int VAL_W = 20
)(
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire logic                   ce,
  input  wire logic [`CTS_ADDR_W-1:0] regAddr,
  input  wire logic                   regWrEn,
  input  wire logic                   regRdEn,
  input  wire logic [31:0]            regWrData,
  output logic      [31:0]            regRdData,
  input  wire logic                   pllTick,
  input  wire logic                   pllLocked,
  input  wire logic                   recTick,
  input  wire logic                   rfFieldPresent,
  input  wire logic                   fastOscTick,
  input  wire logic                   slowOscTick,
  input  wire logic                   fieldOn,
  input  wire logic                   fieldOff,
  input  wire logic                   rxStart,
  input  wire logic                   rxEnd,
  input  wire logic                   txStart,
  input  wire logic                   txEnd,
  output logic      [3:0]             timerFlags,
  output logic                        irq
);
  // Widest divide is 256, so eight prescaler bits cover every setting
  localparam int RF_PRESC_W = 8;
  localparam int RF_N       = 3;

  typedef struct packed {
    logic [2:0][31:0]      cfg;
    logic [2:0][VAL_W-1:0] rld;
    logic [31:0]           trimCfg;
    logic [VAL_W-1:0]      trimCnt;
    logic                  trimRun;
    logic [3:0]            flags;
    logic                  halfTog;
    logic [31:0]           rdData;
  } cts_st_t;

  cts_st_t               st_reg;
  cts_st_t               st_next;
  logic                  carrierOk;
  logic                  tick27;
  logic                  carrierTick;
  logic                  trimTick;
  logic [2:0]            armReq;
  logic [2:0]            stopReq;
  logic [2:0]            rfRun;
  logic [2:0]            rfExp;
  logic [2:0][VAL_W-1:0] rfCnt;
  logic [7:0]            trigHit;
  logic                  wrCfg;
  logic                  trimExp;
  logic [31:0]           statusWord;

  // ========================================================================
  // Helpers
  function automatic logic bankHit(input logic [`CTS_ADDR_W-1:0] addr,
                                   input logic [`CTS_ADDR_W-1:0] base,
                                   input int                     idx);
    // Timer banks sit one word apart from their first member
    bankHit = (addr == base + `CTS_ADDR_W'(`CTS_BANK_STRIDE * idx));
  endfunction

  // Counts and reload values are zero-extended onto the read bus
  function automatic logic [31:0] padVal(input logic [VAL_W-1:0] v);
    padVal = 32'(v);
  endfunction

  // ========================================================================
  // Carrier clock: 27.12 MHz ticks halved, from PLL or field recovery
  always_comb
  begin
    carrierOk   = st_reg.trimCfg[`CTS_TRIM_SRC_REC] ? rfFieldPresent : pllLocked;
    // A source switch mid-run may cut one carrier period short; switch while idle
    tick27      = st_reg.trimCfg[`CTS_TRIM_SRC_REC] ? recTick : pllTick;
    carrierTick = carrierOk & tick27 & st_reg.halfTog;
    // Oscillator ticks are ignored with no carrier present
    trimTick    = carrierOk
      & (st_reg.trimCfg[`CTS_TRIM_SLOW] ? slowOscTick : fastOscTick);
    trigHit     = {st_reg.trimRun, txEnd, txStart, rxEnd, rxStart,
                   fieldOff, fieldOn, 1'b1};
    // Status: flags, two spare bits, trim zero, rf running a..c, trim running
    statusWord  = {21'h00_0000, st_reg.trimRun, rfRun, st_reg.trimCnt == '0,
                   2'h0, st_reg.flags};
  end

  // ========================================================================
  // Three RF timers
  genvar gi;
  generate
    // Each timer has its own prescaler, so divide settings never interact
    for (gi = 0; gi < RF_N; gi++)
    begin : g_rf
      cts_rf_counter #(
        .VAL_W   (VAL_W),
        .PRESC_W (RF_PRESC_W)
      ) u_cnt (
        .clk_sys     (clk_sys),
        .rst         (rst),
        .ce          (ce),
        .carrierTick (carrierTick),
        .armReq      (armReq[gi]),
        .stopReq     (stopReq[gi]),
        .trigSel     (cts_trig_t'(st_reg.cfg[gi][`CTS_CFG_TRIG_MSB:`CTS_CFG_TRIG_LSB])),
        .trigHit     (trigHit),
        .reloadEn    (st_reg.cfg[gi][`CTS_CFG_RELOAD_EN]),
        .reloadVal   (st_reg.rld[gi]),
        .prescSel    (st_reg.cfg[gi][`CTS_CFG_PRESC_MSB:`CTS_CFG_PRESC_LSB]),
        .count       (rfCnt[gi]),
        .running     (rfRun[gi]),
        .expired     (rfExp[gi])
      );
    end
  endgenerate

  // ========================================================================
  // Register file, trimming timer and flags
  always_comb
  begin
    st_next = st_reg;
    armReq  = '0;
    stopReq = '0;
    wrCfg   = 1'b0;
    trimExp = 1'b0;
    if (carrierOk & tick27)
    begin
      st_next.halfTog = ~st_reg.halfTog;
    end

    // Trimming timer counts down on its oscillator ticks
    if (st_reg.trimRun & trimTick)
    begin
      st_next.trimCnt = st_reg.trimCnt - 1'b1;
      if (ctsAtEnd(st_reg.trimCnt))
      begin
        st_next.trimCnt = '0;
        st_next.trimRun = 1'b0;
        trimExp         = 1'b1;
      end
    end

    if (regWrEn)
    begin
      for (int i = 0; i < RF_N; i++)
      begin
        wrCfg = bankHit(regAddr, `CTS_OFS_CFG_A, i);
        if (wrCfg)
        begin
          // Start and stop are commands and read back as zero
          st_next.cfg[i] = regWrData & `CTS_CFG_KEEP_MASK;
          armReq[i]      = regWrData[`CTS_CFG_START];
          stopReq[i]     = regWrData[`CTS_CFG_STOP];
        end
        if (bankHit(regAddr, `CTS_OFS_RLD_A, i))
        begin
          st_next.rld[i] = regWrData[`CTS_VAL_MSB:0];
        end
      end
      // Stop wins over start, so a stray start bit cannot restart the timer
      if (regAddr == `CTS_OFS_TRIM_CFG)
      begin
        st_next.trimCfg = regWrData & `CTS_TRIM_KEEP_MASK;
        if (regWrData[`CTS_TRIM_STOP])
        begin
          st_next.trimRun = 1'b0;
        end
        else if (regWrData[`CTS_TRIM_START])
        begin
          st_next.trimRun = 1'b1;
          st_next.trimCnt = regWrData[`CTS_TRIM_VAL_MSB:0];
        end
      end
      if (regAddr == `CTS_OFS_FLAGS_CLR)
      begin
        st_next.flags = st_reg.flags & ~regWrData[3:0];
      end
    end

    // A new expiry wins over a clear in the same cycle
    st_next.flags = st_next.flags | {trimExp, rfExp};

    // Read data is registered and lands the edge after the strobe
    if (regRdEn)
    begin
      unique case (regAddr)
        `CTS_OFS_CFG_A:    st_next.rdData = st_reg.cfg[0];
        `CTS_OFS_CFG_B:    st_next.rdData = st_reg.cfg[1];
        `CTS_OFS_CFG_C:    st_next.rdData = st_reg.cfg[2];
        `CTS_OFS_RLD_A:    st_next.rdData = padVal(st_reg.rld[0]);
        `CTS_OFS_RLD_B:    st_next.rdData = padVal(st_reg.rld[1]);
        `CTS_OFS_RLD_C:    st_next.rdData = padVal(st_reg.rld[2]);
        `CTS_OFS_OUT_A:    st_next.rdData = padVal(rfCnt[0]);
        `CTS_OFS_OUT_B:    st_next.rdData = padVal(rfCnt[1]);
        `CTS_OFS_OUT_C:    st_next.rdData = padVal(rfCnt[2]);
        `CTS_OFS_TRIM_CFG: st_next.rdData = st_reg.trimCfg;
        `CTS_OFS_FLAGS:    st_next.rdData = statusWord;
        default:           st_next.rdData = `CTS_RST_VAL;
      endcase
    end
  end

  // All state, read data included, is frozen while ce is low
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_reg <= '0;
    end
    else if (ce)
    begin
      st_reg <= st_next;
    end
  end

  assign regRdData  = st_reg.rdData;
  assign timerFlags = st_reg.flags;
  assign irq        = |st_reg.flags;
endmodule

// >>> verilog/cts_map.svh
`ifndef CTS_MAP_SVH
`define CTS_MAP_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define CTS_ADDR_W          14
`define CTS_BANK_STRIDE     4
`define CTS_OFS_CFG_A       14'h0078
`define CTS_OFS_CFG_B       14'h007C
`define CTS_OFS_CFG_C       14'h0080
`define CTS_OFS_RLD_A       14'h0084
`define CTS_OFS_RLD_B       14'h0088
`define CTS_OFS_RLD_C       14'h008C
`define CTS_OFS_OUT_A       14'h0090
`define CTS_OFS_OUT_B       14'h0094
`define CTS_OFS_OUT_C       14'h0098
`define CTS_OFS_TRIM_CFG    14'h009C
`define CTS_OFS_FLAGS       14'h3FE0
`define CTS_OFS_FLAGS_CLR   14'h3FE8

// ==========================================================================
// Fields
`define CTS_RST_VAL         32'h0000_0000
`define CTS_CFG_PRESC_LSB   0
`define CTS_CFG_PRESC_MSB   2
`define CTS_CFG_TRIG_LSB    3
`define CTS_CFG_TRIG_MSB    5
`define CTS_CFG_RELOAD_EN   6
`define CTS_CFG_START       7
`define CTS_CFG_STOP        8
`define CTS_CFG_KEEP_MASK   32'h0000_007F
`define CTS_TRIM_VAL_MSB    19
`define CTS_TRIM_SLOW       20
`define CTS_TRIM_START      21
`define CTS_TRIM_STOP       22
`define CTS_TRIM_SRC_REC    24
`define CTS_TRIM_KEEP_MASK  32'h011F_FFFF
`define CTS_VAL_MSB         19

`endif

// >>> verilog/cts_pkg.sv
package cts_pkg;
  typedef enum logic [2:0] {
    CTS_TRIG_NOW, CTS_TRIG_FIELD_ON, CTS_TRIG_FIELD_OFF, CTS_TRIG_RX_START,
    CTS_TRIG_RX_END, CTS_TRIG_TX_START, CTS_TRIG_TX_END, CTS_TRIG_TRIM_RUN
  } cts_trig_t;

  typedef enum logic [1:0] {CTS_IDLE, CTS_ARMED, CTS_RUN} cts_mode_t;

  // True when the next count step reaches zero
  function automatic logic ctsAtEnd(input logic [19:0] cnt);
    ctsAtEnd = (cnt <= 20'h0_0001);
  endfunction
endpackage

// >>> verilog/cts_rf_counter.sv
`timescale 1ns/1ps
`include "cts_map.svh"
module cts_rf_counter
  import cts_pkg::*;
#(
  parameter int VAL_W   = 20,
  parameter int PRESC_W = 8
)(
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             carrierTick,
  input  wire logic             armReq,
  input  wire logic             stopReq,
  input  wire cts_trig_t        trigSel,
  input  wire logic [7:0]       trigHit,
  input  wire logic             reloadEn,
  input  wire logic [VAL_W-1:0] reloadVal,
  input  wire logic [2:0]       prescSel,
  output logic      [VAL_W-1:0] count,
  output logic                  running,
  output logic                  expired
);
  typedef struct packed {
    cts_mode_t          mode;
    logic [VAL_W-1:0]   cnt;
    logic [PRESC_W-1:0] presc;
    logic               exp;
  } cts_cnt_st_t;

  cts_cnt_st_t st_reg;
  cts_cnt_st_t st_next;
  logic        step;

  // ========================================================================
  // Prescaler: tick every 2^(sel+1) carrier cycles
  always_comb
  begin
    step = carrierTick
      & (&(st_reg.presc | ~(PRESC_W'((2 << prescSel) - 1))));
  end

  // ========================================================================
  // Counter
  always_comb
  begin
    st_next     = st_reg;
    st_next.exp = 1'b0;
    if (carrierTick)
    begin
      st_next.presc = st_reg.presc + 1'b1;
    end
    if (stopReq)
    begin
      st_next.mode = CTS_IDLE;
    end
    else if (armReq)
    begin
      st_next.mode = CTS_ARMED;
    end
    else
    begin
      unique case (st_reg.mode)
        CTS_ARMED:
        begin
          if (trigHit[trigSel])
          begin
            st_next.mode  = CTS_RUN;
            st_next.cnt   = reloadVal;
            st_next.presc = '0;
          end
        end
        CTS_RUN:
        begin
          if (step)
          begin
            st_next.cnt = st_reg.cnt - 1'b1;
            if (ctsAtEnd(st_reg.cnt))
            begin
              st_next.exp = 1'b1;
              if (reloadEn)
              begin
                st_next.cnt = reloadVal;
              end
              else
              begin
                st_next.cnt  = '0;
                st_next.mode = CTS_IDLE;
              end
            end
          end
        end
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_reg <= '{mode: CTS_IDLE, cnt: '0, presc: '0, exp: 1'b0};
    end
    else if (ce)
    begin
      st_reg <= st_next;
    end
  end

  assign count   = st_reg.cnt;
  assign running = (st_reg.mode == CTS_RUN);
  assign expired = st_reg.exp;
endmodule

// >>> bench/cts_timer_set_monitor.sv
`timescale 1ns/1ps
`include "cts_map.svh"
// ==========================================================================
// Port checker
module cts_timer_set_monitor
  import cts_pkg::*;
#(
  parameter int VAL_W = 20
)(
  input wire logic                   clk_sys,
  input wire logic                   rst,
  input wire logic                   ce,
  input wire logic [`CTS_ADDR_W-1:0] regAddr,
  input wire logic                   regWrEn,
  input wire logic                   regRdEn,
  input wire logic [31:0]            regRdData,
  input wire logic                   pllLocked,
  input wire logic                   rfFieldPresent,
  input wire logic [3:0]             timerFlags,
  input wire logic                   irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire clrWr = ce && regWrEn && (regAddr == `CTS_OFS_FLAGS_CLR);
  wire noSrc = !pllLocked && !rfFieldPresent;
  // Read data may land one edge late, so checks skip a back-to-back read
  sequence rdAt(logic [`CTS_ADDR_W-1:0] a);
    ce && regRdEn && regAddr == a ##1 !regRdEn;
  endsequence
  chk_irq_is_or: assert property (irq == |timerFlags)
    else $error("irq differs from OR of flags");
  chk_flag_sticky: assert property (!clrWr |=> (timerFlags & $past(timerFlags)) == $past(timerFlags))
    else $error("flag dropped without clear");
  chk_ce_freeze: assert property (!ce |=> $stable(timerFlags) && $stable(regRdData))
    else $error("state moved with ce low");
  chk_unmapped_zero: assert property (rdAt(14'h00A0) |=> regRdData == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_trim_start_rd: assert property (rdAt(`CTS_OFS_TRIM_CFG) |=> regRdData[22:21] == 2'h0)
    else $error("trim start or stop bit reads set");
  chk_count_width: assert property (rdAt(`CTS_OFS_OUT_A) |=> regRdData[31:20] == 12'h000)
    else $error("count wider than 20 bits");
  chk_no_carrier: assert property (noSrc [*4] |-> (timerFlags & ~$past(timerFlags)) == 4'h0)
    else $error("timer expired without carrier");
  chk_rdata_holds: assert property (!regRdEn ##1 !regRdEn |=> $stable(regRdData))
    else $error("read data changed without read");
  cover property ($rose(timerFlags[0]));
  cover property ($rose(timerFlags[3]));
  cover property (clrWr && irq);
endmodule

bind cts_timer_set cts_timer_set_monitor #(.VAL_W(VAL_W)) mon (.clk_sys(clk_sys), .rst(rst),
  .ce(ce), .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
  .pllLocked(pllLocked), .rfFieldPresent(rfFieldPresent), .timerFlags(timerFlags), .irq(irq));

// >>> bench/cts_timer_set_test.sv
`timescale 1ns/1ps
`include "cts_map.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
// ==========================================================================
// Testbench
module cts_timer_set_test;
  logic        clk_sys = 0, rst = 1, ce = 1, regWrEn = 0, regRdEn = 0, ph = 0, slowEn = 0;
  logic        pllLocked = 0, rfFieldPresent = 0;
  logic [13:0] regAddr   = 14'h0000;
  logic [31:0] regWrData = 32'h0000_0000;
  logic [31:0] rdv;
  logic [5:0]  ev        = 6'h00;
  wire  [31:0] regRdData;
  wire  [3:0]  timerFlags;
  wire         irq;
  int          bad_count = 0, n_checks = 0, n;
  logic [13:0] rstList [10] = '{`CTS_OFS_CFG_A, `CTS_OFS_CFG_B, `CTS_OFS_CFG_C, `CTS_OFS_RLD_A,
    `CTS_OFS_RLD_B, `CTS_OFS_RLD_C, `CTS_OFS_OUT_A, `CTS_OFS_OUT_B, `CTS_OFS_OUT_C,
    `CTS_OFS_TRIM_CFG};

  // Every tick source pulses on alternate cycles; slow osc only when enabled
  cts_timer_set uut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .regAddr(regAddr),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
    .pllTick(ph), .pllLocked(pllLocked), .recTick(ph), .rfFieldPresent(rfFieldPresent),
    .fastOscTick(ph), .slowOscTick(ph & slowEn), .fieldOn(ev[0]), .fieldOff(ev[1]),
    .rxStart(ev[2]), .rxEnd(ev[3]), .txStart(ev[4]), .txEnd(ev[5]),
    .timerFlags(timerFlags), .irq(irq));

  always #4 clk_sys = ~clk_sys;
  always @(negedge clk_sys) ph <= ~ph;

  task automatic results;
    if (bad_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    @(negedge clk_sys);
    regAddr = a;
    regWrData = d;
    regWrEn = 1;
    @(negedge clk_sys);
    regWrEn = 0;
  endtask

  // Waits a spare cycle so either read latency reading is covered
  task automatic chkRd(input string nm, input logic [13:0] a, input logic [31:0] e);
    @(negedge clk_sys);
    regAddr = a;
    regRdEn = 1;
    @(negedge clk_sys);
    regRdEn = 0;
    @(negedge clk_sys);
    `CHK(nm, e, regRdData)
  endtask

  task automatic waitFlag(input int i, input int lim);
    n = 0;
    while (timerFlags[i] !== 1'b1)
    begin
      @(negedge clk_sys);
      n++;
      if (n > lim)
      begin
        $display("ERROR flag %0d exp 1 got 0", i);
        bad_count++;
        results();
      end
    end
  endtask

  task automatic s_reset;
    foreach (rstList[i])
      chkRd("reset value", rstList[i], 32'h0000_0000);
    // Status bit 6 shows trim count zero while the trim timer is idle
    chkRd("reset status", `CTS_OFS_FLAGS, 32'h0000_0040);
    `CHK("irq at reset", 1'b0, irq)
  endtask

  task automatic s_regs;
    wr(`CTS_OFS_CFG_C, 32'hFFFF_FF7F);
    chkRd("cfg c", `CTS_OFS_CFG_C, 32'h0000_007F);
    wr(`CTS_OFS_RLD_A, 32'hFFFF_FFFF);
    chkRd("reload a", `CTS_OFS_RLD_A, 32'h000F_FFFF);
    wr(14'h00A0, 32'hFFFF_FFFF);
    chkRd("unmapped", 14'h00A0, 32'h0000_0000);
    wr(`CTS_OFS_TRIM_CFG, 32'h00FF_FFFF);
    chkRd("trim cfg", `CTS_OFS_TRIM_CFG, 32'h001F_FFFF);
    wr(`CTS_OFS_TRIM_CFG, 32'h0000_0000);
    wr(`CTS_OFS_CFG_C, 32'h0000_0000);
  endtask

  // Carrier tick every 4 cycles; one step per 2^(sel+1) carrier ticks
  task automatic s_presc;
    for (int s = 0; s < 8; s++)
    begin
      wr(`CTS_OFS_RLD_A, 32'h0000_0001);
      wr(`CTS_OFS_CFG_A, 32'h0000_0080 | s);
      waitFlag(0, 2000);
      `CHK("prescale time", 1'b1, (n >= (4 << (s + 1)) - 12) && (n <= (4 << (s + 1)) + 8))
      `CHK("irq on expiry", 1'b1, irq)
      chkRd("status idle", `CTS_OFS_FLAGS, 32'h0000_0041);
      chkRd("count zero", `CTS_OFS_OUT_A, 32'h0000_0000);
      wr(`CTS_OFS_FLAGS_CLR, 32'h0000_0001);
      `CHK("irq cleared", 1'b0, irq)
    end
  endtask

  task automatic s_reload;
    wr(`CTS_OFS_RLD_A, 32'h0000_0003);
    wr(`CTS_OFS_CFG_A, 32'h0000_00C0);
    waitFlag(0, 200);
    `CHK("three steps", 1'b1, (n >= 12) && (n <= 40))
    wr(`CTS_OFS_FLAGS_CLR, 32'h0000_0001);
    @(negedge clk_sys);
    ce = 0;
    repeat (30) @(negedge clk_sys);
    ce = 1;
    waitFlag(0, 200);
    // Status bit 7 is rf timer a running
    chkRd("still running", `CTS_OFS_FLAGS, 32'h0000_00C1);
    wr(`CTS_OFS_CFG_A, 32'h0000_0100);
    wr(`CTS_OFS_FLAGS_CLR, 32'h0000_0001);
    repeat (60) @(negedge clk_sys);
    `CHK("stopped", 1'b0, timerFlags[0])
  endtask

  task automatic s_trig;
    for (int k = 1; k < 7; k++)
    begin
      wr(`CTS_OFS_RLD_B, 32'h0000_0001);
      wr(`CTS_OFS_CFG_B, 32'h0000_0080 | (k << 3));
      repeat (40) @(negedge clk_sys);
      `CHK("waits trigger", 1'b0, timerFlags[1])
      ev[k-1] = 1;
      @(negedge clk_sys);
      ev = 6'h00;
      waitFlag(1, 60);
      wr(`CTS_OFS_FLAGS_CLR, 32'h0000_0002);
    end
  endtask

  task automatic s_trim;
    wr(`CTS_OFS_RLD_C, 32'h0000_0001);
    wr(`CTS_OFS_CFG_C, 32'h0000_00B8);
    repeat (40) @(negedge clk_sys);
    `CHK("waits trim", 1'b0, timerFlags[2])
    wr(`CTS_OFS_TRIM_CFG, 32'h0020_0003);
    waitFlag(3, 100);
    waitFlag(2, 100);
    wr(`CTS_OFS_FLAGS_CLR, 32'h0000_000C);
    wr(`CTS_OFS_TRIM_CFG, 32'h0030_0002);
    repeat (60) @(negedge clk_sys);
    `CHK("slow osc idle", 1'b0, timerFlags[3])
    slowEn = 1;
    waitFlag(3, 100);
    wr(`CTS_OFS_FLAGS_CLR, 32'h0000_0008);
    pllLocked = 0;
    wr(`CTS_OFS_TRIM_CFG, 32'h0020_0002);
    repeat (60) @(negedge clk_sys);
    `CHK("no carrier", 1'b0, timerFlags[3])
    pllLocked = 1;
    wr(`CTS_OFS_TRIM_CFG, 32'h0120_0002);
    repeat (40) @(negedge clk_sys);
    `CHK("no field", 1'b0, timerFlags[3])
    rfFieldPresent = 1;
    waitFlag(3, 100);
  endtask

  initial
  begin
    repeat (10) @(negedge clk_sys);
    rst = 0;
    s_reset();
    s_regs();
    pllLocked = 1;
    s_presc();
    s_reload();
    s_trig();
    s_trim();
    results();
  end
endmodule
